/* logic/clsd_cfg.svh */
// constants for the curtain status display block
`ifndef CLSD_CFG_SVH
`define CLSD_CFG_SVH

`define CLSD_ADDR_W 8
`define CLSD_DATA_W 32

`define CLSD_OFF_CTRL 8'h00
`define CLSD_OFF_STATUS 8'h04
`define CLSD_OFF_IRQ_STAT 8'h08
`define CLSD_OFF_IRQ_EN 8'h0c
`define CLSD_OFF_IRQ_CLR 8'h10

`define CLSD_CTRL_LAMPTEST 0
`define CLSD_CTRL_RESET 1'h0
`define CLSD_IRQ_EN_RESET 4'h0

`define CLSD_EV_CHANNEL 0
`define CLSD_EV_CHANGEOVER 1
`define CLSD_EV_ERROR 2
`define CLSD_EV_TEACHFAIL 3
`define CLSD_EV_W 4

`define CLSD_CLK_KHZ 125000
`define CLSD_TICK_MS 50
`define CLSD_PHASE_TICKS 5'h14
`define CLSD_HALF_1HZ_TICKS 5'h0a
`define CLSD_SHORT_TICKS 5'h01
`define CLSD_BURST_TICKS 3'h4

`endif

/* logic/clsd_pkg.sv */
// types shared by the curtain status display block
package clsd_pkg;

	typedef enum logic [1:0] {
		RI_OFF = 2'h0,
		RI_RELEASED = 2'h1,
		RI_BLOCKED = 2'h2
	} clsd_interlock_t;

	typedef struct packed {
		logic powerGood;
		logic safetySwitchOutputOn;
		logic weakSignal;
		logic extError;
		logic intError;
		clsd_interlock_t restartInterlock;
		logic fieldClear;
		logic linkedEnable;
		logic upstreamOpen;
		logic upstreamChange;
		logic changeTwoFlashes;
		logic teachOk;
		logic teachBusy;
		logic teachFail;
		logic mutingActive;
		logic mutingRestartReq;
		logic mutingOverride;
	} clsd_state_t;

	typedef struct packed {
		logic red1;
		logic green1;
		logic yellow2;
		logic blue3;
	} clsd_leds_t;

	typedef enum logic [2:0] {
		PAT_OFF = 3'h0,
		PAT_ON = 3'h1,
		PAT_1HZ = 3'h2,
		PAT_10HZ = 3'h3,
		PAT_SHORT = 3'h4
	} clsd_pattern_t;

	typedef enum logic [3:0] {
		BST_IDLE = 4'h1,
		BST_ON1 = 4'h2,
		BST_GAP = 4'h4,
		BST_ON2 = 4'h8
	} clsd_burst_t;

endpackage

/* logic/clsd_sync3.sv */
// three-stage synchroniser for the supply pin levels
`timescale 1ns/1ns
`default_nettype none
module clsd_sync3 (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [1:0] pinIn,
	output logic [1:0] pinOut
);
	logic [1:0] s1_q, s2_q, s3_q, out_q;
	logic [1:0] out_d;

	always_comb begin
		out_d = out_q;
		// accept a level only once the last two stages agree
		for (int i = 0; i < 2; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				out_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			s3_q <= 2'h0;
			out_q <= 2'h0;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end

	assign pinOut = out_q;
endmodule
`default_nettype wire

/* logic/clsd_timebase.sv */
// shared blink timebase: 50 ms ticks and a one-second phase
`timescale 1ns/1ns
`default_nettype none
`include "clsd_cfg.svh"
module clsd_timebase #(
	parameter int TICK_CYC = `CLSD_TICK_MS * `CLSD_CLK_KHZ
) (
	input wire logic clk_sys,
	input wire logic rstn,
	output logic tick,
	output logic [4:0] phase
);
	logic [31:0] cnt_q, cnt_d;
	logic [4:0] phase_q, phase_d;
	logic tick_q, tick_d;

	always_comb begin
		cnt_d = cnt_q + 32'h1;
		phase_d = phase_q;
		tick_d = 1'b0;
		if (cnt_q >= 32'(TICK_CYC - 1)) begin
			cnt_d = 32'h0;
			tick_d = 1'b1;
			phase_d = (phase_q == `CLSD_PHASE_TICKS - 5'h1) ? 5'h0
				: phase_q + 5'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 32'h0;
			phase_q <= 5'h0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			phase_q <= phase_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
	assign phase = phase_q;
endmodule
`default_nettype wire

/* logic/clsd_display.sv */
// curtain receiver status display: three leds and channel select
//
// Operation
// [RULE1] supply A high, B low selects channel one; reversed selects two.
// [RULE2] safety outputs on: led one steady green, 1 Hz green if signal weak.
// [RULE3] led one red steady outputs off, 1 Hz external, 10 Hz internal error.
// [RULE4] led two dark: interlock off, released, or blocked with field interrupted.
// [RULE5] led two steady yellow: interlock blocked, field clear, linked sensor enables.
// [RULE6] led two blinks yellow while the upstream safety circuit is open.
// [RULE7] upstream changeover gives a yellow burst of one or two flashes.
// [RULE8] led three dark when no blanking or muting function is active.
// [RULE9] led three steady blue once blanking parameters are taught correctly.
// [RULE10] led three blinks blue at 1 Hz while muting is active.
// [RULE11] short blue flashes: teaching, muting restart needed, muting override.
// [RULE12] led three blinks blue at 10 Hz when teaching failed.
// [RULE13] all blink rates come from one timebase so equal rates stay in phase.
// [RULE14] errors outrank operational indications; led one dark when unpowered.
`timescale 1ns/1ns
`default_nettype none
`include "clsd_cfg.svh"
module clsd_display import clsd_pkg::*; #(
	parameter int TICK_CYC = `CLSD_TICK_MS * `CLSD_CLK_KHZ
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire clsd_state_t devState,
	input wire logic supplyPinA,
	input wire logic supplyPinB,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	output clsd_leds_t leds,
	output logic opticalChannelOne,
	output logic opticalChannelTwo,
	output logic irq
);

	function automatic logic patLevel(input clsd_pattern_t p,
		input logic [4:0] ph);
		case (p)
			PAT_OFF: patLevel = 1'b0;
			PAT_ON: patLevel = 1'b1;
			PAT_1HZ: patLevel = (ph < `CLSD_HALF_1HZ_TICKS);
			PAT_10HZ: patLevel = ~ph[0];
			PAT_SHORT: patLevel = (ph < `CLSD_SHORT_TICKS);
			default: patLevel = 1'b0;
		endcase
	endfunction

	function automatic logic isAddr(input logic [7:0] a,
		input logic [7:0] off);
		isAddr = (a == off);
	endfunction

	logic tick;
	logic [4:0] phase;
	logic [1:0] supplySync;

	// one timebase for every led keeps equal rates in phase [RULE13]
	clsd_timebase #(
		.TICK_CYC(TICK_CYC)
	) u_timebase (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.tick(tick),
		.phase(phase)
	);

	// pins are asynchronous; glitches under two cycles never reach a channel
	clsd_sync3 u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pinIn({supplyPinB, supplyPinA}),
		.pinOut(supplySync)
	);

	// channel select
	// equal pin levels select neither channel
	logic chanOne_q, chanOne_d, chanTwo_q, chanTwo_d;

	always_comb begin
		chanOne_d = supplySync[0] & ~supplySync[1]; // [RULE1]
		chanTwo_d = ~supplySync[0] & supplySync[1]; // [RULE1]
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			chanOne_q <= 1'b0;
			chanTwo_q <= 1'b0;
		end else begin
			chanOne_q <= chanOne_d;
			chanTwo_q <= chanTwo_d;
		end
	end

	// changeover burst; each step lasts a fixed number of ticks
	clsd_burst_t bst_q, bst_d;
	logic [2:0] bstCnt_q, bstCnt_d;
	logic bstTwo_q, bstTwo_d;
	logic stepDone;

	always_comb begin
		bst_d = bst_q;
		bstCnt_d = bstCnt_q;
		bstTwo_d = bstTwo_q;
		stepDone = tick && (bstCnt_q == `CLSD_BURST_TICKS - 3'h1);
		if (tick) begin
			bstCnt_d = stepDone ? 3'h0 : bstCnt_q + 3'h1;
		end
		case (bst_q)
			BST_IDLE: begin
				bstCnt_d = 3'h0;
			end
			BST_ON1: begin
				if (stepDone) begin
					bst_d = bstTwo_q ? BST_GAP : BST_IDLE; // [RULE7]
				end
			end
			BST_GAP: begin
				if (stepDone) begin
					bst_d = BST_ON2;
				end
			end
			BST_ON2: begin
				if (stepDone) begin
					bst_d = BST_IDLE;
				end
			end
			default: begin
				bst_d = BST_IDLE;
			end
		endcase
		// a new changeover restarts the burst from its first flash
		if (devState.upstreamChange) begin
			bst_d = BST_ON1; // [RULE7]
			bstCnt_d = 3'h0;
			bstTwo_d = devState.changeTwoFlashes;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bst_q <= BST_IDLE;
			bstCnt_q <= 3'h0;
			bstTwo_q <= 1'b0;
		end else begin
			bst_q <= bst_d;
			bstCnt_q <= bstCnt_d;
			bstTwo_q <= bstTwo_d;
		end
	end

	// led pattern selection
	clsd_pattern_t redPat, greenPat, yellowPat, bluePat;
	logic burstLit;

	always_comb begin
		redPat = PAT_OFF;
		greenPat = PAT_OFF;
		yellowPat = PAT_OFF;
		bluePat = PAT_OFF;
		burstLit = (bst_q == BST_ON1) || (bst_q == BST_ON2);
		if (!devState.powerGood) begin
			redPat = PAT_OFF; // [RULE14]
		end else if (devState.intError) begin
			redPat = PAT_10HZ; // [RULE3] [RULE14]
		end else if (devState.extError) begin
			redPat = PAT_1HZ; // [RULE3] [RULE14]
		end else if (devState.safetySwitchOutputOn) begin
			greenPat = devState.weakSignal ? PAT_1HZ : PAT_ON; // [RULE2]
		end else begin
			redPat = PAT_ON; // [RULE3]
		end
		if (bst_q != BST_IDLE) begin
			yellowPat = burstLit ? PAT_ON : PAT_OFF; // [RULE7]
		end else if (devState.upstreamOpen) begin
			yellowPat = PAT_1HZ; // [RULE6]
		end else if (devState.restartInterlock == RI_BLOCKED
			&& devState.fieldClear && devState.linkedEnable) begin
			yellowPat = PAT_ON; // [RULE5]
		end else begin
			yellowPat = PAT_OFF; // [RULE4]
		end
		if (devState.teachFail) begin
			bluePat = PAT_10HZ; // [RULE12] [RULE14]
		end else if (devState.teachBusy || devState.mutingRestartReq
			|| devState.mutingOverride) begin
			bluePat = PAT_SHORT; // [RULE11]
		end else if (devState.mutingActive) begin
			bluePat = PAT_1HZ; // [RULE10]
		end else if (devState.teachOk) begin
			bluePat = PAT_ON; // [RULE9]
		end else begin
			bluePat = PAT_OFF; // [RULE8]
		end
	end

	// register file
	logic lampTest_q, lampTest_d;
	logic [3:0] irqEn_q, irqEn_d, irqStat_q, irqStat_d;
	logic [31:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic errPrev_q, errPrev_d, failPrev_q, failPrev_d;
	logic [3:0] events;
	clsd_leds_t leds_q, leds_d;

	always_comb begin
		leds_d.red1 = patLevel(redPat, phase);
		leds_d.green1 = patLevel(greenPat, phase);
		leds_d.yellow2 = patLevel(yellowPat, phase);
		leds_d.blue3 = patLevel(bluePat, phase);
		// lamp test lights everything while the device has power
		if (lampTest_q && devState.powerGood) begin
			leds_d = 4'hf;
		end
	end

	// leds leave straight from flops, so no decode glitch reaches a pin
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			leds_q <= 4'h0;
		end else begin
			leds_q <= leds_d;
		end
	end

	// level memories for the rising-edge events; an error already
	// present at reset release still counts as a rise
	always_comb begin
		errPrev_d = devState.intError | devState.extError;
		failPrev_d = devState.teachFail;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			errPrev_q <= 1'b0;
			failPrev_q <= 1'b0;
		end else begin
			errPrev_q <= errPrev_d;
			failPrev_q <= failPrev_d;
		end
	end

	always_comb begin
		events = 4'h0;
		events[`CLSD_EV_CHANNEL] = (chanOne_d != chanOne_q)
			|| (chanTwo_d != chanTwo_q);
		events[`CLSD_EV_CHANGEOVER] = devState.upstreamChange;
		events[`CLSD_EV_ERROR] = errPrev_d & ~errPrev_q;
		events[`CLSD_EV_TEACHFAIL] = failPrev_d & ~failPrev_q;
		lampTest_d = lampTest_q;
		irqEn_d = irqEn_q;
		irqStat_d = irqStat_q;
		if (regWr && isAddr(regAddr, `CLSD_OFF_CTRL)) begin
			lampTest_d = regWdata[`CLSD_CTRL_LAMPTEST];
		end
		if (regWr && isAddr(regAddr, `CLSD_OFF_IRQ_EN)) begin
			irqEn_d = regWdata[3:0];
		end
		if (regWr && isAddr(regAddr, `CLSD_OFF_IRQ_CLR)) begin
			irqStat_d = irqStat_q & ~regWdata[3:0];
		end
		// set after clear so a same-cycle event is never lost
		irqStat_d = irqStat_d | events;
		irq_d = |(irqStat_d & irqEn_d);
		rdata_d = 32'h0;
		if (regRd) begin
			case (regAddr)
				`CLSD_OFF_CTRL: rdata_d = {31'h0, lampTest_q};
				`CLSD_OFF_STATUS: rdata_d = {21'h0, bst_q != BST_IDLE,
					chanTwo_q, chanOne_q, 4'h0, leds_q};
				`CLSD_OFF_IRQ_STAT: rdata_d = {28'h0, irqStat_q};
				`CLSD_OFF_IRQ_EN: rdata_d = {28'h0, irqEn_q};
				default: rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lampTest_q <= `CLSD_CTRL_RESET;
			irqEn_q <= `CLSD_IRQ_EN_RESET;
			irqStat_q <= 4'h0;
			rdata_q <= 32'h0;
			irq_q <= 1'b0;
		end else begin
			lampTest_q <= lampTest_d;
			irqEn_q <= irqEn_d;
			irqStat_q <= irqStat_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	assign regRdata = rdata_q;
	assign leds = leds_q;
	assign opticalChannelOne = chanOne_q;
	assign opticalChannelTwo = chanTwo_q;
	assign irq = irq_q;
endmodule
`default_nettype wire

/* tb/clsd_display_asserts.sv */
// assertion checker for the curtain status display
`timescale 1ns/1ns
`default_nettype none
`include "clsd_cfg.svh"
module clsd_display_chk import clsd_pkg::*; #(
	parameter int TICK_CYC = 4
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire clsd_state_t devState,
	input wire logic supplyPinA,
	input wire logic supplyPinB,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire clsd_leds_t leds,
	input wire logic opticalChannelOne,
	input wire logic opticalChannelTwo,
	input wire logic irq
);
	clsd_state_t s;
	logic [1:0] lamp_q, lamp_d;
	logic [31:0] age_q, age_d;
	logic quiet, calm, err, rdy, mute;
	assign s = devState;
	// lamp test and burst hide the normal patterns, so mask around them
	assign quiet = lamp_q == 2'h0 && age_q > 32'h2;
	assign calm = quiet && age_q > 32'(16 * TICK_CYC);
	assign err = s.intError | s.extError;
	assign rdy = s.restartInterlock == RI_BLOCKED && s.fieldClear
		&& s.linkedEnable;
	assign mute = {s.teachBusy, s.teachFail, s.mutingRestartReq,
		s.mutingOverride} == 4'h0;
	always_comb begin
		lamp_d = {lamp_q[0], lamp_q[0]};
		if (regWr && regAddr == `CLSD_OFF_CTRL)
			lamp_d[0] = regWdata[0];
		age_d = s.upstreamChange ? 32'h0 : age_q + {31'h0, ~&age_q};
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lamp_q <= 2'h0;
			age_q <= 32'h0;
		end else begin
			lamp_q <= lamp_d;
			age_q <= age_d;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_chanOne;
		(supplyPinA && !supplyPinB)[*7] |=> opticalChannelOne
			&& !opticalChannelTwo;
	endproperty
	a_chanOne: assert property (p_chanOne) else $error("chan one");
	property p_chanTwo;
		(!supplyPinA && supplyPinB)[*7] |=> opticalChannelTwo
			&& !opticalChannelOne;
	endproperty
	a_chanTwo: assert property (p_chanTwo) else $error("chan two");
	property p_green;
		quiet && s.powerGood && s.safetySwitchOutputOn && !s.weakSignal && !err
			|=> leds.green1 && !leds.red1;
	endproperty
	a_green: assert property (p_green) else $error("green");
	property p_red;
		quiet && s.powerGood && !s.safetySwitchOutputOn && !err
			|=> leds.red1 && !leds.green1;
	endproperty
	a_red: assert property (p_red) else $error("red");
	property p_steady2;
		calm && !s.upstreamOpen && rdy |=> leds.yellow2;
	endproperty
	a_steady2: assert property (p_steady2) else $error("yellow");
	property p_dark2;
		calm && !s.upstreamOpen && !rdy |=> !leds.yellow2;
	endproperty
	a_dark2: assert property (p_dark2) else $error("yellow dark");
	property p_burst;
		s.upstreamChange |-> ##[1:3] leds.yellow2;
	endproperty
	a_burst: assert property (p_burst) else $error("burst");
	property p_dark3;
		quiet && mute && !s.mutingActive && !s.teachOk |=> !leds.blue3;
	endproperty
	a_dark3: assert property (p_dark3) else $error("blue dark");
	property p_phase;
		quiet && s.powerGood && s.safetySwitchOutputOn && s.weakSignal && !err
			&& s.mutingActive && mute |=> leds.green1 == leds.blue3;
	endproperty
	a_phase: assert property (p_phase) else $error("phase");
	c_two: cover property (s.upstreamChange && s.changeTwoFlashes);
	c_fail: cover property (s.teachFail && leds.blue3);
	c_irq: cover property (irq);
endmodule
bind clsd_display clsd_display_chk #(.TICK_CYC(TICK_CYC)) i_clsd_display_chk (
	.clk_sys(clk_sys), .rstn(rstn), .devState(devState),
	.supplyPinA(supplyPinA), .supplyPinB(supplyPinB), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.leds(leds), .opticalChannelOne(opticalChannelOne),
	.opticalChannelTwo(opticalChannelTwo), .irq(irq));
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the curtain status display
`timescale 1ns/1ns
`default_nettype none
module tb_top import clsd_pkg::*;;
	typedef struct {clsd_state_t s; logic [31:0] on, tog;} clsd_row_t;
	logic clk_sys = 1'b0, rstn = 1'b0, pinA = 1'b0, pinB = 1'b0;
	logic regWr = 1'b0, regRd = 1'b0, chan1, chan2, irq;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata;
	logic [7:0] onC[4], togC[4];
	clsd_state_t st = '0;
	clsd_leds_t leds;
	int fails = 0, checks = 0;
	// on counts and toggles per 80-cycle second, bytes {red,green,yellow,blue}
	clsd_row_t rows[17] = '{
		'{18'h00000, 32'h0, 32'h0},
		'{18'h30000, 32'h00500000, 32'h0},
		'{18'h38000, 32'h00280000, 32'h00020000},
		'{18'h20000, 32'h50000000, 32'h0},
		'{18'h34000, 32'h28000000, 32'h02000000},
		'{18'h36000, 32'h28000000, 32'h14000000},
		'{18'h21600, 32'h50005000, 32'h0},
		'{18'h21200, 32'h50000000, 32'h0},
		'{18'h20e00, 32'h50000000, 32'h0},
		'{18'h21700, 32'h50002800, 32'h00000200},
		'{18'h20020, 32'h50000050, 32'h0},
		'{18'h20024, 32'h50000028, 32'h00000002},
		'{18'h20010, 32'h50000004, 32'h00000002},
		'{18'h20002, 32'h50000004, 32'h00000002},
		'{18'h20005, 32'h50000004, 32'h00000002},
		'{18'h20018, 32'h50000028, 32'h00000014},
		'{18'h38004, 32'h00280028, 32'h00020002}
	};
	clsd_display #(.TICK_CYC(4)) i_clsd_display (.clk_sys(clk_sys),
		.rstn(rstn), .devState(st), .supplyPinA(pinA), .supplyPinB(pinB),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .leds(leds), .opticalChannelOne(chan1),
		.opticalChannelTwo(chan2), .irq(irq));
	always #4 clk_sys = ~clk_sys;
	task automatic end_of_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		chk(regRdata, exp);
	endtask
	// a full blink second, so phase alignment does not matter
	task automatic meas();
		clsd_leds_t p, c;
		onC = '{default: 8'h0};
		togC = '{default: 8'h0};
		cyc(1);
		p = leds;
		for (int i = 0; i < 80; i++) begin
			cyc(1);
			c = leds;
			for (int b = 0; b < 4; b++) begin
				onC[b] += {7'h0, p[3-b]};
				togC[b] += {7'h0, p[3-b] !== c[3-b]};
			end
			p = c;
		end
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h40, 32'h0);
		$display("registers done");
		foreach (rows[i]) begin
			@(posedge clk_sys);
			st <= rows[i].s;
			cyc(3);
			meas();
			chk({onC[0], onC[1], onC[2], onC[3]}, rows[i].on);
			chk({togC[0], togC[1], togC[2], togC[3]}, rows[i].tog);
		end
		$display("patterns done");
		for (int n = 1; n < 3; n++) begin
			@(posedge clk_sys);
			st <= n == 2 ? 18'h200c0 : 18'h20080;
			@(posedge clk_sys);
			st <= 18'h20000;
			meas();
			// the first rise lands before the window opens
			chk(togC[2], 2 * n - 1);
			chk(onC[2] > 16 * n - 5 && onC[2] <= 16 * n, 1);
		end
		$display("burst done");
		rd(8'h08, 32'he);
		wr(8'h10, 32'hf);
		wr(8'h0c, 32'h1);
		pinA <= 1'b1;
		cyc(10);
		chk({chan1, chan2, irq}, 3'h5);
		rd(8'h08, 32'h1);
		rd(8'h04, 32'h108);
		wr(8'h10, 32'h1);
		cyc(3);
		chk(irq, 1'h0);
		wr(8'h0c, 32'h0);
		pinA <= 1'b0;
		pinB <= 1'b1;
		cyc(10);
		chk({chan1, chan2, irq}, 3'h2);
		rd(8'h08, 32'h1);
		rd(8'h10, 32'h0);
		@(posedge clk_sys);
		pinA <= 1'b1;
		cyc(10);
		chk({chan1, chan2}, 2'h0);
		wr(8'h00, 32'h1);
		cyc(3);
		chk(leds, 4'hf);
		rd(8'h04, 32'hf);
		wr(8'h00, 32'h0);
		$display("channel and irq done");
		@(posedge clk_sys);
		rstn <= 1'b0;
		cyc(2);
		chk({25'h0, leds, chan1, chan2, irq}, 32'h0);
		chk(regRdata, 32'h0);
		@(posedge clk_sys);
		rstn <= 1'b1;
		rd(8'h00, 32'h0);
		$display("reset done");
		end_of_test();
	end
endmodule
`default_nettype wire
